// ### logic/fifo_port_defines.vh
// Constants for the byte-wide USB parallel FIFO port.
`ifndef FIFO_PORT_DEFINES_VH
`define FIFO_PORT_DEFINES_VH

// ----------------------------------------------------------------
// Buffers
// ----------------------------------------------------------------
`define RX_DEPTH      128
`define RX_AW         7
`define TX_DEPTH      384
`define TX_AW         9

// ----------------------------------------------------------------
// Clock rates and enables
// ----------------------------------------------------------------
`define SYS_MHZ       200
`define REF_MHZ       12
`define DPLL_MHZ      48
`define ACC_W         8

// ----------------------------------------------------------------
// Reset generator
// ----------------------------------------------------------------
`define RST_HOLD_US   5000
`define RST_HOLD_CYC  (`RST_HOLD_US * `SYS_MHZ)
`define RST_CNT_W     21

// ----------------------------------------------------------------
// Configuration memory
// ----------------------------------------------------------------
`define CFG_WORDS     64
`define CFG_AW        6
`define CFG_W_OPT     6'h00
`define CFG_W_VID     6'h01
`define CFG_W_PID     6'h02
`define CFG_W_PWR     6'h03
`define CFG_W_LAST    6'h3f
`define CFG_OPT_USB2  0
`define CFG_OPT_SER   1
`define CFG_BLANK     16'hffff
`define CFG_CHK_SEED  16'haaaa
`define BCD_USB11     16'h0110
`define BCD_USB20     16'h0200
`define DEF_VID       16'h1d50
`define DEF_PID       16'h0a0b
`define DEF_PWR       16'h002d

`endif

// ### logic/usb_parallel_fifo_port.v
// Byte-wide parallel FIFO port with reset generator and configuration loader.
`timescale 1ns/1ps
`include "fifo_port_defines.vh"

// Overview of operation
// - Host OUT bytes wait in a 128-byte receive buffer until read by strobe.
// - Written bytes go to a 384-byte transmit buffer, drained by IN requests.
// - Data lines are driven with the current receive byte while read strobe is low.
// - Read strobe rising edge advances to the next receive byte if present.
// - Write strobe falling edge captures the data lines into the transmit buffer.
// - Data flag is low while receive data waits; reads happen only then.
// - FIFO logic runs on a 12MHz enable; a 48MHz enable feeds data recovery.
// - Reset output is low during any internal reset, high otherwise.
// - Reset output stays low about 5ms after supply, oscillator and reset input are good.
// - Low external reset input resets the device; otherwise held high.
// - Absent, blank or invalid configuration gives default identifiers and no serial.
// - A configuration option reports a USB 2.0 descriptor, still full speed.
// - Only the first 64 configuration words are used; others free during reset.
// - After each accepted write the space flag rises, high while full or storing.
// - After each read the data flag rises, falling only when another byte is ready.

module usb_parallel_fifo_port
#(
  parameter RX_DEPTH     = `RX_DEPTH,
  parameter TX_DEPTH     = `TX_DEPTH,
  parameter RST_HOLD_CYC = `RST_HOLD_CYC,
  parameter DEFAULT_VID  = `DEF_VID,   // Arbitrary value.
  parameter DEFAULT_PID  = `DEF_PID    // Arbitrary value.
)
(
  input  wire                clk_sys,
  input  wire                arst_n,
  input  wire                ext_reset_n,
  input  wire                osc_running,
  output reg                 reset_out_n,
  output wire                ref_tick,
  output wire                dpll_tick,
  input  wire [7:0]          fifo_bus_in,
  output reg  [7:0]          fifo_bus_out,
  output reg                 fifo_bus_oe,
  input  wire                rd_strobe_n,
  input  wire                wr_strobe,
  output reg                 tx_space_flag_n,
  output reg                 rx_avail_flag_n,
  input  wire                rx_in_valid,
  input  wire [7:0]          rx_in_data,
  output wire                rx_in_ready,
  output reg                 tx_out_valid,
  output reg  [7:0]          tx_out_data,
  input  wire                tx_out_ready,
  output reg                 cfg_req,
  output reg  [`CFG_AW-1:0]  cfg_addr,
  input  wire                cfg_ack,
  input  wire [15:0]         cfg_data,
  output wire                cfg_ext_allow,
  output reg                 cfg_done,
  output reg  [15:0]         desc_vid,
  output reg  [15:0]         desc_pid,
  output reg  [15:0]         desc_power,
  output reg  [15:0]         desc_bcd_usb,
  output reg                 desc_serial_en
);

  // ----------------------------------------------------------------
  // Rate enables
  // ----------------------------------------------------------------
  // Phase accumulators give exact average rates from the 200MHz clock.
  reg  [`ACC_W-1:0] ref_acc_reg;
  reg  [`ACC_W-1:0] dpll_acc_reg;
  wire [`ACC_W:0]   ref_sum;
  wire [`ACC_W:0]   dpll_sum;

  localparam [`ACC_W:0] REF_STEP  = `REF_MHZ;
  localparam [`ACC_W:0] DPLL_STEP = `DPLL_MHZ;
  localparam [`ACC_W:0] SYS_STEP  = `SYS_MHZ;

  assign ref_sum   = {1'b0, ref_acc_reg} + REF_STEP;
  assign dpll_sum  = {1'b0, dpll_acc_reg} + DPLL_STEP;
  assign ref_tick  = osc_running && (ref_sum >= SYS_STEP);
  assign dpll_tick = osc_running && (dpll_sum >= SYS_STEP);

  always @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ref_acc_reg  <= {`ACC_W{1'b0}};
      dpll_acc_reg <= {`ACC_W{1'b0}};
    end
    else if (osc_running)
    begin
      ref_acc_reg  <= ref_tick ? ref_sum[`ACC_W-1:0] - SYS_STEP[`ACC_W-1:0] : ref_sum[`ACC_W-1:0];
      dpll_acc_reg <= dpll_tick ? dpll_sum[`ACC_W-1:0] - SYS_STEP[`ACC_W-1:0] : dpll_sum[`ACC_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Reset generator
  // ----------------------------------------------------------------
  reg                  ext_rst_s1_reg;
  reg                  ext_rst_s2_reg;
  reg  [`RST_CNT_W-1:0] rst_cnt_reg;
  wire                 rst_cond;
  wire                 core_rst;

  assign rst_cond      = !ext_rst_s2_reg || !osc_running;
  assign core_rst      = !reset_out_n;
  // Outside access waits until the loader has dropped its request.
  assign cfg_ext_allow = core_rst && !cfg_req;

  always @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ext_rst_s1_reg <= 1'b0;
      ext_rst_s2_reg <= 1'b0;
      rst_cnt_reg    <= {`RST_CNT_W{1'b0}};
      reset_out_n    <= 1'b0;
    end
    else
    begin
      ext_rst_s1_reg <= ext_reset_n;
      ext_rst_s2_reg <= ext_rst_s1_reg;
      if (rst_cond)
      begin
        rst_cnt_reg <= {`RST_CNT_W{1'b0}};
        reset_out_n <= 1'b0;
      end
      else if (rst_cnt_reg == RST_HOLD_CYC[`RST_CNT_W-1:0] - 1'b1)
        reset_out_n <= 1'b1;
      else
        rst_cnt_reg <= rst_cnt_reg + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Strobe synchronisers
  // ----------------------------------------------------------------
  reg  rd_s1_reg;
  reg  rd_s2_reg;
  reg  rd_prev_reg;
  reg  wr_s1_reg;
  reg  wr_s2_reg;
  reg  wr_prev_reg;
  wire rd_rise;
  wire wr_fall;

  // Edges are judged only on the 12MHz enable, so strobes must stay
  // in each level for at least one 12MHz period to be seen.
  assign rd_rise = ref_tick && rd_s2_reg && !rd_prev_reg;
  assign wr_fall = ref_tick && !wr_s2_reg && wr_prev_reg;

  always @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rd_s1_reg   <= 1'b1;
      rd_s2_reg   <= 1'b1;
      rd_prev_reg <= 1'b1;
      wr_s1_reg   <= 1'b0;
      wr_s2_reg   <= 1'b0;
      wr_prev_reg <= 1'b0;
      fifo_bus_oe <= 1'b0;
    end
    else
    begin
      rd_s1_reg   <= rd_strobe_n;
      rd_s2_reg   <= rd_s1_reg;
      wr_s1_reg   <= wr_strobe;
      wr_s2_reg   <= wr_s1_reg;
      fifo_bus_oe <= !rd_s2_reg && !core_rst;
      if (ref_tick)
      begin
        rd_prev_reg <= rd_s2_reg;
        wr_prev_reg <= wr_s2_reg;
      end
    end
  end

  // ----------------------------------------------------------------
  // Receive buffer
  // ----------------------------------------------------------------
  reg  [7:0]       rx_mem [0:RX_DEPTH-1];
  reg  [`RX_AW:0]  rx_wptr_reg;
  reg  [`RX_AW:0]  rx_rptr_reg;
  wire             rx_empty;
  wire             rx_full;
  wire             rx_push;

  assign rx_empty    = rx_wptr_reg == rx_rptr_reg;
  assign rx_full     = (rx_wptr_reg[`RX_AW] != rx_rptr_reg[`RX_AW]) &&
                       (rx_wptr_reg[`RX_AW-1:0] == rx_rptr_reg[`RX_AW-1:0]);
  assign rx_in_ready = ref_tick && !rx_full && !core_rst;
  assign rx_push     = rx_in_valid && rx_in_ready;

  always @(posedge clk_sys)
  begin
    if (rx_push)
      rx_mem[rx_wptr_reg[`RX_AW-1:0]] <= rx_in_data;
  end

  always @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rx_wptr_reg     <= {(`RX_AW+1){1'b0}};
      rx_rptr_reg     <= {(`RX_AW+1){1'b0}};
      fifo_bus_out    <= 8'h00;
      rx_avail_flag_n <= 1'b1;
    end
    else if (core_rst)
    begin
      rx_wptr_reg     <= {(`RX_AW+1){1'b0}};
      rx_rptr_reg     <= {(`RX_AW+1){1'b0}};
      rx_avail_flag_n <= 1'b1;
    end
    else
    begin
      if (rx_push)
        rx_wptr_reg <= rx_wptr_reg + 1'b1;
      if (rd_rise)
      begin
        rx_avail_flag_n <= 1'b1;
        if (!rx_empty && !rx_avail_flag_n)
          rx_rptr_reg <= rx_rptr_reg + 1'b1;
      end
      else if (ref_tick && rd_s2_reg)
      begin
        // The head byte is refreshed only while the strobe is high, so
        // the lines never change under a read in progress.
        fifo_bus_out    <= rx_mem[rx_rptr_reg[`RX_AW-1:0]];
        rx_avail_flag_n <= rx_empty;
      end
    end
  end

  // ----------------------------------------------------------------
  // Transmit buffer
  // ----------------------------------------------------------------
  reg  [7:0]       tx_mem [0:TX_DEPTH-1];
  reg  [`TX_AW-1:0] tx_wptr_reg;
  reg  [`TX_AW-1:0] tx_rptr_reg;
  reg  [`TX_AW:0]   tx_count_reg;
  reg  [7:0]        tx_hold_reg;
  reg               tx_pend_reg;
  wire              tx_store;
  wire              tx_pop;
  wire              tx_full;

  assign tx_full  = tx_count_reg == TX_DEPTH;
  assign tx_store = ref_tick && tx_pend_reg;
  assign tx_pop   = tx_out_valid && tx_out_ready;

  always @(posedge clk_sys)
  begin
    if (tx_store)
      tx_mem[tx_wptr_reg] <= tx_hold_reg;
  end

  always @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tx_wptr_reg     <= {`TX_AW{1'b0}};
      tx_rptr_reg     <= {`TX_AW{1'b0}};
      tx_count_reg    <= {(`TX_AW+1){1'b0}};
      tx_hold_reg     <= 8'h00;
      tx_pend_reg     <= 1'b0;
      tx_space_flag_n <= 1'b1;
      tx_out_valid    <= 1'b0;
      tx_out_data     <= 8'h00;
    end
    else if (core_rst)
    begin
      tx_wptr_reg     <= {`TX_AW{1'b0}};
      tx_rptr_reg     <= {`TX_AW{1'b0}};
      tx_count_reg    <= {(`TX_AW+1){1'b0}};
      tx_pend_reg     <= 1'b0;
      tx_space_flag_n <= 1'b1;
      tx_out_valid    <= 1'b0;
    end
    else
    begin
      // A write while the flag is high breaks the handshake and is dropped.
      if (wr_fall && !tx_space_flag_n)
      begin
        tx_hold_reg     <= fifo_bus_in;
        tx_pend_reg     <= 1'b1;
        tx_space_flag_n <= 1'b1;
      end
      else if (tx_store)
      begin
        tx_pend_reg     <= 1'b0;
        tx_wptr_reg     <= (tx_wptr_reg == TX_DEPTH - 1) ? {`TX_AW{1'b0}} : tx_wptr_reg + 1'b1;
        tx_space_flag_n <= 1'b1;
      end
      else if (ref_tick)
        tx_space_flag_n <= tx_full;
      if (tx_store && !tx_pop)
        tx_count_reg <= tx_count_reg + 1'b1;
      else if (tx_pop && !tx_store)
        tx_count_reg <= tx_count_reg - 1'b1;
      if (tx_pop)
      begin
        tx_out_valid <= 1'b0;
        tx_rptr_reg  <= (tx_rptr_reg == TX_DEPTH - 1) ? {`TX_AW{1'b0}} : tx_rptr_reg + 1'b1;
      end
      else if (ref_tick && !tx_out_valid && tx_count_reg != 0)
      begin
        tx_out_data  <= tx_mem[tx_rptr_reg];
        tx_out_valid <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Configuration loader
  // ----------------------------------------------------------------
  localparam CFG_IDLE = 2'd0;
  localparam CFG_REQ  = 2'd1;
  localparam CFG_EVAL = 2'd2;
  localparam CFG_DONE = 2'd3;

  reg  [1:0]  cfg_state_reg;
  reg  [15:0] cfg_chk_reg;
  reg  [15:0] cfg_opt_reg;
  reg  [15:0] cfg_vid_reg;
  reg  [15:0] cfg_pid_reg;
  reg  [15:0] cfg_pwr_reg;
  wire        cfg_valid;

  assign cfg_valid = (cfg_chk_reg == `CFG_CHK_SEED) && (cfg_vid_reg != `CFG_BLANK);

  always @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cfg_state_reg  <= CFG_IDLE;
      cfg_req        <= 1'b0;
      cfg_addr       <= {`CFG_AW{1'b0}};
      cfg_done       <= 1'b0;
      cfg_chk_reg    <= 16'h0000;
      cfg_opt_reg    <= 16'h0000;
      cfg_vid_reg    <= 16'h0000;
      cfg_pid_reg    <= 16'h0000;
      cfg_pwr_reg    <= 16'h0000;
      desc_vid       <= DEFAULT_VID;
      desc_pid       <= DEFAULT_PID;
      desc_power     <= `DEF_PWR;
      desc_bcd_usb   <= `BCD_USB11;
      desc_serial_en <= 1'b0;
    end
    else if (core_rst)
    begin
      // The memory belongs to outside logic while the device is in reset.
      cfg_state_reg <= CFG_IDLE;
      cfg_req       <= 1'b0;
      cfg_done      <= 1'b0;
    end
    else
    begin
      case (cfg_state_reg)
        CFG_IDLE:
        begin
          cfg_addr      <= {`CFG_AW{1'b0}};
          cfg_chk_reg   <= 16'h0000;
          cfg_req       <= 1'b1;
          cfg_state_reg <= CFG_REQ;
        end
        CFG_REQ:
        begin
          if (cfg_ack)
          begin
            cfg_chk_reg <= cfg_chk_reg ^ cfg_data;
            if (cfg_addr == `CFG_W_OPT)
              cfg_opt_reg <= cfg_data;
            else if (cfg_addr == `CFG_W_VID)
              cfg_vid_reg <= cfg_data;
            else if (cfg_addr == `CFG_W_PID)
              cfg_pid_reg <= cfg_data;
            else if (cfg_addr == `CFG_W_PWR)
              cfg_pwr_reg <= cfg_data;
            if (cfg_addr == `CFG_W_LAST)
            begin
              cfg_req       <= 1'b0;
              cfg_state_reg <= CFG_EVAL;
            end
            else
              cfg_addr <= cfg_addr + 1'b1;
          end
        end
        CFG_EVAL:
        begin
          if (cfg_valid)
          begin
            desc_vid       <= cfg_vid_reg;
            desc_pid       <= cfg_pid_reg;
            desc_power     <= cfg_pwr_reg;
            desc_serial_en <= cfg_opt_reg[`CFG_OPT_SER];
            desc_bcd_usb   <= cfg_opt_reg[`CFG_OPT_USB2] ? `BCD_USB20 : `BCD_USB11;
          end
          else
          begin
            desc_vid       <= DEFAULT_VID;
            desc_pid       <= DEFAULT_PID;
            desc_power     <= `DEF_PWR;
            desc_serial_en <= 1'b0;
            desc_bcd_usb   <= `BCD_USB11;
          end
          cfg_done      <= 1'b1;
          cfg_state_reg <= CFG_DONE;
        end
        default:
          cfg_done <= 1'b1;
      endcase
    end
  end

endmodule

// ### sim/usb_parallel_fifo_port_properties.sv
// Concurrent checks on the parallel FIFO port pins.
`timescale 1ns/1ps
module usb_parallel_fifo_port_properties
#(
  parameter RST_HOLD_CYC = 20
)
(
  input wire clk_sys,
  input wire arst_n,
  input wire ext_reset_n,
  input wire osc_running,
  input wire reset_out_n,
  input wire ref_tick,
  input wire dpll_tick,
  input wire fifo_bus_oe,
  input wire rd_strobe_n,
  input wire wr_strobe,
  input wire tx_space_flag_n,
  input wire rx_avail_flag_n,
  input wire rx_in_ready,
  input wire tx_out_valid,
  input wire tx_out_ready,
  input wire cfg_req,
  input wire cfg_ext_allow
);
  // ------------------------------------------------------------
  // Helper count of cycles with all reset causes inactive
  // ------------------------------------------------------------
  integer good_cnt;
  always @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      good_cnt <= 0;
    else if (!(ext_reset_n && osc_running))
      good_cnt <= 0;
    else if (good_cnt < 100000)
      good_cnt <= good_cnt + 1;
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  property p_oe_cause; fifo_bus_oe |-> !$past(rd_strobe_n, 3); endproperty
  a_oe_cause: assert property (p_oe_cause) else $error("bus driven without read strobe");
  property p_oe_drive; (!rd_strobe_n && reset_out_n) [*4] |-> fifo_bus_oe; endproperty
  a_oe_drive: assert property (p_oe_drive) else $error("bus not driven during read");
  property p_rx_release; $rose(rd_strobe_n) && !rx_avail_flag_n |-> ##[1:30] rx_avail_flag_n; endproperty
  a_rx_release: assert property (p_rx_release) else $error("data flag not raised after read");
  property p_tx_taken; $fell(wr_strobe) && !tx_space_flag_n |-> ##[1:30] tx_space_flag_n; endproperty
  a_tx_taken: assert property (p_tx_taken) else $error("space flag not raised after write");
  property p_ready_tick; rx_in_ready |-> ref_tick && reset_out_n; endproperty
  a_ready_tick: assert property (p_ready_tick) else $error("receive push outside reference tick");
  property p_ref_gap; ref_tick |=> !ref_tick [*8]; endproperty
  a_ref_gap: assert property (p_ref_gap) else $error("reference ticks too close");
  property p_ref_next; disable iff (!arst_n || !osc_running) ref_tick |-> ##[16:17] ref_tick; endproperty
  a_ref_next: assert property (p_ref_next) else $error("reference tick spacing wrong");
  property p_dpll; disable iff (!arst_n || !osc_running) dpll_tick |-> ##[4:5] dpll_tick; endproperty
  a_dpll: assert property (p_dpll) else $error("recovery tick spacing wrong");
  property p_ext_rst; $fell(ext_reset_n) |-> ##[1:4] !reset_out_n; endproperty
  a_ext_rst: assert property (p_ext_rst) else $error("external reset not seen on reset output");
  property p_hold_min; $rose(reset_out_n) |-> good_cnt >= RST_HOLD_CYC; endproperty
  a_hold_min: assert property (p_hold_min) else $error("reset output released early");
  property p_hold_max; good_cnt == RST_HOLD_CYC + 8 |-> reset_out_n; endproperty
  a_hold_max: assert property (p_hold_max) else $error("reset output held too long");
  property p_pop; tx_out_valid && tx_out_ready |=> !tx_out_valid; endproperty
  a_pop: assert property (p_pop) else $error("transmit byte not removed on drain");
  property p_allow; cfg_ext_allow |-> !reset_out_n && !cfg_req; endproperty
  a_allow: assert property (p_allow) else $error("memory access allowed outside reset");

  c_read: cover property (!rx_avail_flag_n && !rd_strobe_n);
  c_drain: cover property (tx_out_valid && tx_out_ready);
  c_release: cover property ($rose(reset_out_n));
endmodule

bind usb_parallel_fifo_port usb_parallel_fifo_port_properties #(.RST_HOLD_CYC(RST_HOLD_CYC)) props_inst (
  .clk_sys(clk_sys), .arst_n(arst_n), .ext_reset_n(ext_reset_n), .osc_running(osc_running),
  .reset_out_n(reset_out_n), .ref_tick(ref_tick), .dpll_tick(dpll_tick), .fifo_bus_oe(fifo_bus_oe),
  .rd_strobe_n(rd_strobe_n), .wr_strobe(wr_strobe), .tx_space_flag_n(tx_space_flag_n),
  .rx_avail_flag_n(rx_avail_flag_n), .rx_in_ready(rx_in_ready), .tx_out_valid(tx_out_valid),
  .tx_out_ready(tx_out_ready), .cfg_req(cfg_req), .cfg_ext_allow(cfg_ext_allow));

// ### sim/fifo_ext_logic_model.sv
// Model of the external logic and configuration memory beside the FIFO port.
`timescale 1ns/1ps
`include "fifo_port_defines.vh"
module fifo_ext_logic_model
(
  input  wire              clk_sys,
  input  wire [7:0]        fifo_bus_out,
  input  wire              fifo_bus_oe,
  output wire [7:0]        fifo_bus_in,
  output reg               rd_strobe_n,
  output reg               wr_strobe,
  input  wire              tx_space_flag_n,
  input  wire              rx_avail_flag_n,
  input  wire              cfg_req,
  input  wire [`CFG_AW-1:0] cfg_addr,
  output reg               cfg_ack,
  output reg  [15:0]       cfg_data
);
  reg [15:0] cfg_mem [0:63];
  reg [7:0]  drv;
  reg        drv_en;
  reg [7:0]  last;
  integer    i;

  // A bus nobody drives shows a changing pattern, so a stale byte cannot pass.
  assign fifo_bus_in = fifo_bus_oe ? fifo_bus_out : (drv_en ? drv : ~last);

  initial
  begin
    rd_strobe_n = 1'b1;
    wr_strobe = 1'b0;
    drv = 8'h00;
    drv_en = 1'b0;
    last = 8'h00;
    cfg_ack = 1'b0;
    cfg_data = 16'h0000;
    for (i = 0; i < 64; i = i + 1)
      cfg_mem[i] = `CFG_BLANK;
  end

  always @(posedge clk_sys)
  begin
    last <= fifo_bus_in;
    cfg_ack <= cfg_req & ~cfg_ack;
    cfg_data <= cfg_ack ? ~cfg_data : cfg_mem[cfg_addr];
  end

  task wr_byte(input [7:0] b, input ign, output ok);
    integer n;
    begin
      n = 0;
      while (!ign && tx_space_flag_n !== 1'b0 && n < 400)
      begin
        @(negedge clk_sys);
        n = n + 1;
      end
      ok = (tx_space_flag_n === 1'b0);
      @(posedge clk_sys);
      #1;
      drv = b;
      drv_en = 1'b1;
      wr_strobe = 1'b1;
      repeat (24) @(posedge clk_sys);
      #1;
      wr_strobe = 1'b0;
      repeat (25) @(posedge clk_sys);
      #1;
      drv_en = 1'b0;
    end
  endtask

  task rd_byte(output [7:0] b, output oe, output ok);
    integer n;
    begin
      n = 0;
      while (rx_avail_flag_n !== 1'b0 && n < 200)
      begin
        @(negedge clk_sys);
        n = n + 1;
      end
      ok = (rx_avail_flag_n === 1'b0);
      @(posedge clk_sys);
      #1;
      rd_strobe_n = 1'b0;
      repeat (24) @(posedge clk_sys);
      #1;
      b = fifo_bus_in;
      oe = fifo_bus_oe;
      rd_strobe_n = 1'b1;
      repeat (40) @(posedge clk_sys);
      #1;
    end
  endtask
endmodule

// ### sim/usb_parallel_fifo_port_bench.sv
// Self-checking bench for the parallel FIFO port.
`timescale 1ns/1ps
`include "fifo_port_defines.vh"
`define CHK(nm, e, g) begin cmp_count = cmp_count + 1; if ((g) !== (e)) begin fails = fails + 1; \
  $display("ERROR %s exp %h got %h", nm, e, g); end end
`define WAIT_FOR(c, lim) begin n = 0; while (!(c) && n < lim) begin @(negedge clk_sys); n = n + 1; end end
module usb_parallel_fifo_port_bench;
  localparam HOLD = 20;
  reg         clk_sys = 1'b0;
  reg         arst_n = 1'b0;
  reg         ext_reset_n = 1'b1;
  reg         osc_running = 1'b1;
  reg         rx_in_valid = 1'b0;
  reg  [7:0]  rx_in_data = 8'h00;
  reg         tx_out_ready = 1'b0;
  wire        reset_out_n, ref_tick, dpll_tick, fifo_bus_oe, rd_strobe_n, wr_strobe;
  wire        tx_space_flag_n, rx_avail_flag_n, rx_in_ready, tx_out_valid, cfg_req, cfg_ack;
  wire        cfg_ext_allow, cfg_done, desc_serial_en;
  wire [7:0]  fifo_bus_in, fifo_bus_out, tx_out_data;
  wire [5:0]  cfg_addr;
  wire [15:0] cfg_data, desc_vid, desc_pid, desc_power, desc_bcd_usb;
  integer     fails = 0, cmp_count = 0, cyc = 0, n, i;
  reg  [7:0]  b;
  reg         oe, ok;

  always #2.5 clk_sys = ~clk_sys;

  usb_parallel_fifo_port #(.RST_HOLD_CYC(HOLD)) usb_parallel_fifo_port_inst (
    .clk_sys(clk_sys), .arst_n(arst_n), .ext_reset_n(ext_reset_n), .osc_running(osc_running),
    .reset_out_n(reset_out_n), .ref_tick(ref_tick), .dpll_tick(dpll_tick), .fifo_bus_in(fifo_bus_in),
    .fifo_bus_out(fifo_bus_out), .fifo_bus_oe(fifo_bus_oe), .rd_strobe_n(rd_strobe_n), .wr_strobe(wr_strobe),
    .tx_space_flag_n(tx_space_flag_n), .rx_avail_flag_n(rx_avail_flag_n), .rx_in_valid(rx_in_valid),
    .rx_in_data(rx_in_data), .rx_in_ready(rx_in_ready), .tx_out_valid(tx_out_valid), .tx_out_data(tx_out_data),
    .tx_out_ready(tx_out_ready), .cfg_req(cfg_req), .cfg_addr(cfg_addr), .cfg_ack(cfg_ack), .cfg_data(cfg_data),
    .cfg_ext_allow(cfg_ext_allow), .cfg_done(cfg_done), .desc_vid(desc_vid), .desc_pid(desc_pid),
    .desc_power(desc_power), .desc_bcd_usb(desc_bcd_usb), .desc_serial_en(desc_serial_en));

  fifo_ext_logic_model fifo_ext_logic_model_inst (
    .clk_sys(clk_sys), .fifo_bus_out(fifo_bus_out), .fifo_bus_oe(fifo_bus_oe), .fifo_bus_in(fifo_bus_in),
    .rd_strobe_n(rd_strobe_n), .wr_strobe(wr_strobe), .tx_space_flag_n(tx_space_flag_n),
    .rx_avail_flag_n(rx_avail_flag_n), .cfg_req(cfg_req), .cfg_addr(cfg_addr), .cfg_ack(cfg_ack),
    .cfg_data(cfg_data));

  task close_out;
  begin
    $display("Comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  end
  endtask

  task push(input [7:0] d);
  begin
    @(posedge clk_sys);
    #1;
    rx_in_valid = 1'b1;
    rx_in_data = d;
    `WAIT_FOR(rx_in_ready, 40)
    `CHK("rx ready", 1'b1, rx_in_ready)
    @(posedge clk_sys);
    #1;
    rx_in_valid = 1'b0;
  end
  endtask

  task t_power_up;
  begin
    `CHK("reset out", 1'b0, reset_out_n)
    `CHK("ext allow", 1'b1, cfg_ext_allow)
    `WAIT_FOR(reset_out_n, 200)
    `CHK("hold", 1'b1, n >= HOLD)
    `WAIT_FOR(cfg_done, 1000)
    `CHK("def desc", {`DEF_VID, `DEF_PID, `DEF_PWR, `BCD_USB11, 1'b0},
      {desc_vid, desc_pid, desc_power, desc_bcd_usb, desc_serial_en})
  end
  endtask

  task t_config;
  begin
    for (i = 0; i < 64; i = i + 1)
      fifo_ext_logic_model_inst.cfg_mem[i] = 16'h0000;
    fifo_ext_logic_model_inst.cfg_mem[0] = 16'h0003;
    fifo_ext_logic_model_inst.cfg_mem[1] = 16'h1234;
    fifo_ext_logic_model_inst.cfg_mem[2] = 16'h5678;
    fifo_ext_logic_model_inst.cfg_mem[3] = 16'h0032;
    fifo_ext_logic_model_inst.cfg_mem[63] = `CFG_CHK_SEED ^ 16'h0003 ^ 16'h1234 ^ 16'h5678 ^ 16'h0032;
    @(posedge clk_sys);
    #1;
    osc_running = 1'b0;
    @(posedge clk_sys);
    #1;
    `CHK("osc loss", 2'b00, {reset_out_n, ref_tick})
    osc_running = 1'b1;
    `WAIT_FOR(reset_out_n, 200)
    @(posedge clk_sys);
    #1;
    ext_reset_n = 1'b0;
    repeat (5) @(posedge clk_sys);
    #1;
    `CHK("ext reset", 1'b0, reset_out_n)
    ext_reset_n = 1'b1;
    `WAIT_FOR(reset_out_n, 200)
    `WAIT_FOR(cfg_done, 1000)
    `CHK("cfg desc", {16'h1234, 16'h5678, 16'h0032, `BCD_USB20, 1'b1},
      {desc_vid, desc_pid, desc_power, desc_bcd_usb, desc_serial_en})
  end
  endtask

  task t_rx;
  begin
    for (i = 0; i < 128; i = i + 1)
      push(8'h3c ^ i[7:0]);
    `WAIT_FOR(rx_in_ready, 40)
    `CHK("rx full", 40, n)
    for (i = 0; i < 128; i = i + 1)
    begin
      fifo_ext_logic_model_inst.rd_byte(b, oe, ok);
      `CHK("rx read", {1'b1, 1'b1, 8'h3c ^ i[7:0]}, {ok, oe, b})
    end
    repeat (60) @(negedge clk_sys);
    `CHK("rx empty", 2'b10, {rx_avail_flag_n, fifo_bus_oe})
  end
  endtask

  task t_tx;
  begin
    `CHK("tx idle", 1'b0, tx_out_valid)
    for (i = 0; i < 384; i = i + 1)
    begin
      fifo_ext_logic_model_inst.wr_byte(8'ha5 ^ i[7:0], 1'b0, ok);
      `CHK("tx space", 1'b1, ok)
    end
    repeat (60) @(negedge clk_sys);
    `CHK("tx full", 1'b1, tx_space_flag_n)
    fifo_ext_logic_model_inst.wr_byte(8'hee, 1'b1, ok);
    `CHK("tx refused", 1'b0, ok)
    for (i = 0; i < 384; i = i + 1)
    begin
      `WAIT_FOR(tx_out_valid, 60)
      `CHK("tx byte", {1'b1, 8'ha5 ^ i[7:0]}, {tx_out_valid, tx_out_data})
      @(posedge clk_sys);
      #1;
      tx_out_ready = 1'b1;
      @(posedge clk_sys);
      #1;
      tx_out_ready = 1'b0;
    end
    repeat (60) @(negedge clk_sys);
    `CHK("tx drained", 2'b00, {tx_out_valid, tx_space_flag_n})
  end
  endtask

  always @(posedge clk_sys)
  begin
    cyc = cyc + 1;
    if (cyc == 90000)
    begin
      fails = fails + 1;
      close_out;
    end
  end

  initial
  begin
    repeat (6) @(posedge clk_sys);
    #1;
    arst_n = 1'b1;
    t_power_up;
    t_config;
    t_rx;
    t_tx;
    close_out;
  end
endmodule
